// ===== core/auir_pkg.sv
// Package of register offsets, field positions, reset values and types for the serial port.
package auir_pkg;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [11:0] OFF_DATA = 12'h000;
  localparam logic [11:0] OFF_RSTAT = 12'h004;
  localparam logic [11:0] OFF_FLAG = 12'h018;
  localparam logic [11:0] OFF_ILPR = 12'h020;
  localparam logic [11:0] OFF_IBRD = 12'h024;
  localparam logic [11:0] OFF_FBRD = 12'h028;
  localparam logic [11:0] OFF_LCTL = 12'h02C;
  localparam logic [11:0] OFF_CTL = 12'h030;
  localparam logic [11:0] OFF_IFLS = 12'h034;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [9:0] CTL_RESET = 10'h300;
  localparam logic [5:0] IFLS_RESET = 6'h12;

  // ****************************************************************
  // Control register bit positions.
  // ****************************************************************
  localparam int CTL_EN = 0;
  localparam int CTL_SIR = 1;
  localparam int CTL_SIRLP = 2;
  localparam int CTL_TXE = 8;
  localparam int CTL_RXE = 9;

  // ****************************************************************
  // Line control bit positions.
  // ****************************************************************
  localparam int LC_BRK = 0;
  localparam int LC_PEN = 1;
  localparam int LC_EPS = 2;
  localparam int LC_STP2 = 3;
  localparam int LC_FEN = 4;
  localparam int LC_WLEN = 5;
  localparam int LC_SPS = 7;

  // ****************************************************************
  // Receive status bit positions; a receive entry holds them eight bits up, in bits 11:8.
  // ****************************************************************
  localparam int ST_FE = 0;
  localparam int ST_PE = 1;
  localparam int ST_BE = 2;
  localparam int ST_OE = 3;

  // ****************************************************************
  // Timing counts in oversample ticks; LP_PULSE counts low-power ticks.
  // ****************************************************************
  localparam logic [3:0] TICKS_HALF = 4'h7;
  localparam logic [3:0] TICKS_LAST = 4'hF;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [1:0] LP_PULSE = 2'h3;

  // Line-control snapshot taken with the divisor.
  typedef struct packed {
    logic [15:0] divInt;
    logic [5:0] divisor_fraction_field;
    logic [7:0] lineCtl;
  } auir_cfg_type;

  // Serializer states.
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } auir_tx_type;

  // Deserializer states.
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } auir_rx_type;

endpackage : auir_pkg

// ===== core/auir_uart.sv
// Asynchronous serial port with FIFOs, fractional baud generator and infrared encoder.
//
// What this block does
// - Transmit and receive enables set after reset; EN starts clear, so nothing runs until it is set.
// - Clearing TXE or RXE finishes the current character; clearing EN freezes it at once.
// - Start, data LSB first, parity, stop.
// - Five to eight bits, parity styles, stops.
// - Divisor: 16-bit integer, 6-bit fraction.
// - Divisor equals clock over sixteen baud.
// - Sixteen-times tick paces bits and sampling.
// - Divisor latched only on line-control write.
// - Sixteen-entry FIFOs, receive entries carry status.
// - Trigger levels one eighth to seven eighths.
// - Send back to back until FIFO empty.
// - Busy until FIFO empty and stop sent.
// - Start valid if low at eighth tick.
// - Sample bits every sixteenth tick, check parity.
// - Stop must be high, else framing error.
// - Parity, framing, break stored per character; overrun kept in sticky status.
// - Control bit selects plain or infrared encoding on the output pin.
// - Infrared zero is three-sixteenths high pulse.
// - Receive input sampled as a plain level in both modes.
// - Low-power pulse is three divided ticks.
// - FIFOs start disabled as one-entry holding registers.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module auir_uart #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite write channels.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins.
  input wire logic serialInPin,
  output logic serialOutPin,
  // FIFO trigger indications.
  output logic txLevelHit,
  output logic rxLevelHit
);

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [9:0] ctl_r; // Control register.
  logic [15:0] ibrd_r; // Integer divisor staging.
  logic [5:0] fbrd_r; // Fraction divisor staging.
  logic [7:0] ilpr_r; // Low-power divisor.
  logic [5:0] ifls_r; // FIFO trigger selects.
  logic [3:0] rstat_r; // Sticky receive status.
  auir_pkg::auir_cfg_type cfg_r; // Active 30-bit configuration.

  // ****************************************************************
  // FIFO storage.
  // ****************************************************************
  logic [7:0] txMem_r [DEPTH];
  logic [11:0] rxMem_r [DEPTH];
  logic [AW:0] txCnt_r, rxCnt_r;
  logic [AW-1:0] txRd_r, txWr_r, rxRd_r, rxWr_r;
  logic [AW:0] cap; // Effective depth.
  logic txFull, rxFull, txEmpty, rxEmpty;
  logic txPush, txPop, rxPush, rxPop;
  logic [11:0] rxEntry; // Entry to push.

  // Depth is one entry while the FIFO is disabled.
  assign cap = cfg_r.lineCtl[auir_pkg::LC_FEN] ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign txFull = (txCnt_r >= cap);
  assign rxFull = (rxCnt_r >= cap);
  assign txEmpty = (txCnt_r == '0);
  assign rxEmpty = (rxCnt_r == '0);

  // ****************************************************************
  // Bus slave.
  // ****************************************************************
  logic awHeld_r, wHeld_r, arHeld_r;
  logic [11:0] awAddr_r, arAddr_r;
  logic [31:0] wData_r;
  logic doWrite, doRead;
  logic [31:0] rdMux;

  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !arHeld_r && !s_axi_rvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;
  assign doWrite = awHeld_r && wHeld_r;
  assign doRead = arHeld_r;

  // Address and data are caught independently so either may come first.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      arHeld_r <= 1'b0;
      awAddr_r <= 12'h000;
      arAddr_r <= 12'h000;
      wData_r <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        arHeld_r <= 1'b1;
        arAddr_r <= s_axi_araddr;
      end
      if (doRead) begin
        arHeld_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  logic busy;
  // Read mux; unmapped addresses read zero with an OKAY answer.
  always_comb begin
    rdMux = 32'h00000000;
    case ({arAddr_r[11:2], 2'h0})
      auir_pkg::OFF_DATA: rdMux = {20'h00000, rxMem_r[rxRd_r]};
      auir_pkg::OFF_RSTAT: rdMux = {28'h0000000, rstat_r};
      auir_pkg::OFF_FLAG: rdMux = {24'h000000, txEmpty, rxFull, txFull, rxEmpty, busy, 3'h0};
      auir_pkg::OFF_ILPR: rdMux = {24'h000000, ilpr_r};
      auir_pkg::OFF_IBRD: rdMux = {16'h0000, ibrd_r};
      auir_pkg::OFF_FBRD: rdMux = {26'h0000000, fbrd_r};
      auir_pkg::OFF_LCTL: rdMux = {24'h000000, cfg_r.lineCtl};
      auir_pkg::OFF_CTL: rdMux = {22'h000000, ctl_r};
      auir_pkg::OFF_IFLS: rdMux = {26'h0000000, ifls_r};
      default: rdMux = 32'h00000000;
    endcase
  end

  assign rxPop = doRead && (arAddr_r == auir_pkg::OFF_DATA) && !rxEmpty;
  assign txPush = doWrite && (awAddr_r == auir_pkg::OFF_DATA) && s_axi_wstrb[0] && !txFull;

  // Configuration registers; the divisor is only taken when line control is written.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_r <= auir_pkg::CTL_RESET;
      ibrd_r <= 16'h0000;
      fbrd_r <= 6'h00;
      ilpr_r <= 8'h00;
      ifls_r <= auir_pkg::IFLS_RESET;
      cfg_r <= '0;
    end else if (doWrite) begin
      case (awAddr_r)
        auir_pkg::OFF_CTL: ctl_r <= wData_r[9:0];
        auir_pkg::OFF_IBRD: ibrd_r <= wData_r[15:0];
        auir_pkg::OFF_FBRD: fbrd_r <= wData_r[5:0];
        auir_pkg::OFF_ILPR: ilpr_r <= wData_r[7:0];
        auir_pkg::OFF_IFLS: ifls_r <= wData_r[5:0];
        auir_pkg::OFF_LCTL: cfg_r <= {ibrd_r, fbrd_r, wData_r[7:0]};
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Fractional baud generator.
  // ****************************************************************
  logic [15:0] intCnt_r;
  logic [6:0] fracAcc_r;
  logic tick; // Oversample tick, one cycle.
  logic [6:0] fracSum;
  assign fracSum = {1'b0, fracAcc_r[5:0]} + {1'b0, cfg_r.divisor_fraction_field};
  assign tick = ctl_r[auir_pkg::CTL_EN] && (cfg_r.divInt != 16'h0000) && (intCnt_r == 16'h0000);

  // Each period is divInt cycles, stretched by one when the 1/64 accumulator carries.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      intCnt_r <= 16'h0000;
      fracAcc_r <= 7'h00;
    end else if (tick) begin
      fracAcc_r <= fracSum;
      intCnt_r <= fracSum[6] ? cfg_r.divInt : cfg_r.divInt - 16'h0001;
    end else if (intCnt_r != 16'h0000) begin
      intCnt_r <= intCnt_r - 16'h0001;
    end
  end

  // Low-power infrared tick: the oversample tick divided by ilpr (zero acts as 256).
  logic [7:0] lpCnt_r;
  logic lpTick;
  assign lpTick = tick && (lpCnt_r == 8'h00);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lpCnt_r <= 8'h00;
    end else if (tick) begin
      lpCnt_r <= (lpCnt_r == 8'h00) ? ilpr_r - 8'h01 : lpCnt_r - 8'h01;
    end
  end

  // ****************************************************************
  // Transmitter.
  // ****************************************************************
  auir_pkg::auir_tx_type txSt_r;
  logic [3:0] txTk_r;
  logic [2:0] txBit_r;
  logic [7:0] txSh_r;
  logic txPar_r, txLine_r, txStop2_r;
  logic [2:0] wlenM1;
  logic [7:0] lc;
  assign lc = cfg_r.lineCtl;
  assign wlenM1 = 3'h4 + {1'b0, lc[auir_pkg::LC_WLEN+1 -: 2]};
  assign txPop = (txSt_r == auir_pkg::TX_IDLE) && !txEmpty && tick
    && ctl_r[auir_pkg::CTL_EN] && ctl_r[auir_pkg::CTL_TXE];
  assign busy = !txEmpty || (txSt_r != auir_pkg::TX_IDLE);

  // Parity bit value for a given data parity.
  function automatic logic parBit(input logic [7:0] l, input logic xorIn);
    if (l[auir_pkg::LC_SPS]) begin
      parBit = !l[auir_pkg::LC_EPS];
    end else begin
      parBit = l[auir_pkg::LC_EPS] ? xorIn : !xorIn;
    end
  endfunction : parBit

  // Character serializer; once started it runs to its stop bits even if TXE clears; clearing EN freezes it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txSt_r <= auir_pkg::TX_IDLE;
      txTk_r <= 4'h0;
      txBit_r <= 3'h0;
      txSh_r <= 8'h00;
      txPar_r <= 1'b0;
      txLine_r <= 1'b1;
      txStop2_r <= 1'b0;
    end else if (txPop) begin
      txSt_r <= auir_pkg::TX_START;
      txSh_r <= txMem_r[txRd_r];
      txPar_r <= 1'b0;
      txTk_r <= 4'h0;
      txLine_r <= 1'b0;
    end else if (tick && txSt_r != auir_pkg::TX_IDLE) begin
      txTk_r <= txTk_r + 4'h1;
      if (txTk_r == auir_pkg::TICKS_LAST) begin
        case (txSt_r)
          auir_pkg::TX_START: begin
            txSt_r <= auir_pkg::TX_DATA;
            txBit_r <= 3'h0;
            txLine_r <= txSh_r[0];
            txPar_r <= txSh_r[0];
          end
          auir_pkg::TX_DATA: begin
            if (txBit_r == wlenM1) begin
              txSt_r <= lc[auir_pkg::LC_PEN] ? auir_pkg::TX_PAR : auir_pkg::TX_STOP;
              txLine_r <= lc[auir_pkg::LC_PEN] ? parBit(lc, txPar_r) : 1'b1;
              txStop2_r <= lc[auir_pkg::LC_STP2];
            end else begin
              txBit_r <= txBit_r + 3'h1;
              txLine_r <= txSh_r[txBit_r + 3'h1];
              txPar_r <= txPar_r ^ txSh_r[txBit_r + 3'h1];
            end
          end
          auir_pkg::TX_PAR: begin
            txSt_r <= auir_pkg::TX_STOP;
            txLine_r <= 1'b1;
            txStop2_r <= lc[auir_pkg::LC_STP2];
          end
          auir_pkg::TX_STOP: begin
            if (txStop2_r) begin
              txStop2_r <= 1'b0;
            end else begin
              txSt_r <= auir_pkg::TX_IDLE;
            end
          end
          default: txSt_r <= auir_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // Infrared encoder: a zero bit becomes a short high pulse, a one stays low.
  logic [1:0] lpPulse_r;
  logic irOut;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lpPulse_r <= 2'h0;
    end else if (txTk_r == 4'h0 && tick && !txLine_r) begin
      lpPulse_r <= auir_pkg::LP_PULSE;
    end else if (lpTick && lpPulse_r != 2'h0) begin
      lpPulse_r <= lpPulse_r - 2'h1;
    end
  end
  always_comb begin
    if (ctl_r[auir_pkg::CTL_SIRLP]) begin
      irOut = !txLine_r && (lpPulse_r != 2'h0);
    end else begin
      irOut = !txLine_r && (txTk_r < auir_pkg::IR_PULSE);
    end
  end

  // Output register; break forces the plain line low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serialOutPin <= 1'b1;
    end else if (ctl_r[auir_pkg::CTL_SIR]) begin
      serialOutPin <= irOut && !lc[auir_pkg::LC_BRK];
    end else begin
      serialOutPin <= txLine_r && !lc[auir_pkg::LC_BRK];
    end
  end

  // ****************************************************************
  // Receiver.
  // ****************************************************************
  logic inS1_r, inS2_r; // Two-stage pin synchroniser.
  logic inPrev_r;
  logic rxIn;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      inS1_r <= 1'b1;
      inS2_r <= 1'b1;
    end else begin
      inS1_r <= serialInPin;
      inS2_r <= inS1_r;
    end
  end
  // Both modes sample the receive line as a plain level; infrared pulses are not decoded.
  assign rxIn = inS2_r;

  auir_pkg::auir_rx_type rxSt_r;
  logic [3:0] rxTk_r;
  logic [2:0] rxBit_r;
  logic [7:0] rxSh_r;
  logic rxPar_r, rxPe_r, rxAllZero_r, rxGo;
  assign rxGo = ctl_r[auir_pkg::CTL_EN] && ctl_r[auir_pkg::CTL_RXE];

  // Deserializer; an accepted start runs to its stop even if receive is disabled; clearing EN freezes it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxSt_r <= auir_pkg::RX_IDLE;
      rxTk_r <= 4'h0;
      rxBit_r <= 3'h0;
      rxSh_r <= 8'h00;
      rxPar_r <= 1'b0;
      rxPe_r <= 1'b0;
      rxAllZero_r <= 1'b0;
      inPrev_r <= 1'b1;
      rxPush <= 1'b0;
      rxEntry <= 12'h000;
    end else begin
      rxPush <= 1'b0;
      if (tick) begin
        inPrev_r <= rxIn;
        rxTk_r <= rxTk_r + 4'h1;
        case (rxSt_r)
          auir_pkg::RX_IDLE: begin
            if (rxGo && inPrev_r && !rxIn) begin
              rxSt_r <= auir_pkg::RX_START;
              rxTk_r <= 4'h1;
            end
          end
          auir_pkg::RX_START: begin
            if (rxTk_r == auir_pkg::TICKS_HALF) begin
              if (rxIn) begin
                rxSt_r <= auir_pkg::RX_IDLE;
              end else begin
                rxSt_r <= auir_pkg::RX_DATA;
                rxTk_r <= 4'h0;
                rxBit_r <= 3'h0;
                rxPar_r <= 1'b0;
                rxAllZero_r <= 1'b1;
              end
            end
          end
          auir_pkg::RX_DATA: begin
            if (rxTk_r == auir_pkg::TICKS_LAST) begin
              rxSh_r[rxBit_r] <= rxIn;
              rxPar_r <= rxPar_r ^ rxIn;
              rxAllZero_r <= rxAllZero_r && !rxIn;
              rxBit_r <= rxBit_r + 3'h1;
              if (rxBit_r == wlenM1) begin
                rxSt_r <= lc[auir_pkg::LC_PEN] ? auir_pkg::RX_PAR : auir_pkg::RX_STOP;
              end
              if (rxBit_r == 3'h0) begin
                rxSh_r[7:1] <= 7'h00;
              end
            end
          end
          auir_pkg::RX_PAR: begin
            if (rxTk_r == auir_pkg::TICKS_LAST) begin
              rxPe_r <= (rxIn != parBit(lc, rxPar_r));
              rxAllZero_r <= rxAllZero_r && !rxIn;
              rxSt_r <= auir_pkg::RX_STOP;
            end
          end
          auir_pkg::RX_STOP: begin
            if (rxTk_r == auir_pkg::TICKS_LAST) begin
              rxSt_r <= auir_pkg::RX_IDLE;
              rxPush <= 1'b1;
              rxEntry[7:0] <= rxSh_r;
              rxEntry[8 + auir_pkg::ST_FE] <= !rxIn;
              rxEntry[8 + auir_pkg::ST_PE] <= lc[auir_pkg::LC_PEN] && rxPe_r;
              rxEntry[8 + auir_pkg::ST_BE] <= rxAllZero_r && !rxIn;
              rxEntry[8 + auir_pkg::ST_OE] <= rxFull;
              rxPe_r <= 1'b0;
            end
          end
          default: rxSt_r <= auir_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // Sticky status; a new error wins over a same-cycle clear write.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rstat_r <= 4'h0;
    end else if (rxPush) begin
      rstat_r <= rstat_r | rxEntry[11:8];
    end else if (doWrite && awAddr_r == auir_pkg::OFF_RSTAT) begin
      rstat_r <= 4'h0;
    end
  end

  // ****************************************************************
  // FIFO pointers; an overrun character is dropped, its flag kept.
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txCnt_r <= '0;
      txRd_r <= '0;
      txWr_r <= '0;
      rxCnt_r <= '0;
      rxRd_r <= '0;
      rxWr_r <= '0;
    end else begin
      if (txPush) begin
        txMem_r[txWr_r] <= wData_r[7:0];
        txWr_r <= txWr_r + 1'b1;
      end
      if (txPop) begin
        txRd_r <= txRd_r + 1'b1;
      end
      txCnt_r <= txCnt_r + (AW+1)'(txPush) - (AW+1)'(txPop);
      if (rxPush && !rxFull) begin
        rxMem_r[rxWr_r] <= rxEntry;
        rxWr_r <= rxWr_r + 1'b1;
      end
      if (rxPop) begin
        rxRd_r <= rxRd_r + 1'b1;
      end
      rxCnt_r <= rxCnt_r + (AW+1)'(rxPush && !rxFull) - (AW+1)'(rxPop);
    end
  end

  // Trigger level: select 0..4 means 2,4,8,12,14 entries of sixteen.
  function automatic logic [AW:0] lvl(input logic [2:0] s);
    case (s)
      3'h0: lvl = (AW+1)'(DEPTH / 8);
      3'h1: lvl = (AW+1)'(DEPTH / 4);
      3'h2: lvl = (AW+1)'(DEPTH / 2);
      3'h3: lvl = (AW+1)'(DEPTH * 3 / 4);
      default: lvl = (AW+1)'(DEPTH * 7 / 8);
    endcase
  endfunction : lvl
  assign txLevelHit = (txCnt_r <= lvl(ifls_r[2:0]));
  assign rxLevelHit = (rxCnt_r >= lvl(ifls_r[5:3]));

endmodule : auir_uart

// ===== sim/auir_line_peer.sv
// Remote serial device: frames the port's output and sends frames to its input.
`timescale 1ns/100ps
module auir_line_peer #(
  parameter int BIT = 16
) (
  // Clock and serial lines.
  input wire logic sys_clk,
  input wire logic serialOutPin,
  output logic serialInPin
);
  // Frames seen: data in 7:0, parity in 8, stop in 9.
  logic [9:0] frames[$];
  logic [9:0] f;
  initial serialInPin = 1'b1;
  // Sample every bit at its middle, counted from the falling start edge.
  always begin
    @(negedge serialOutPin);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT) @(posedge sys_clk);
      f[i] = serialOutPin;
    end
    frames.push_back(f);
  end
  // The task drives the line high after the frame, so it rests high between frames.
  task automatic send(input logic [9:0] frm);
    serialInPin <= 1'b0;
    repeat (BIT) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      serialInPin <= frm[i];
      repeat (BIT) @(posedge sys_clk);
    end
    serialInPin <= 1'b1;
    repeat (BIT) @(posedge sys_clk);
  endtask : send
  // A short low blip that must not be taken for a start bit.
  task automatic glitch();
    serialInPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    serialInPin <= 1'b1;
    repeat (BIT) @(posedge sys_clk);
  endtask : glitch
endmodule : auir_line_peer

// ===== sim/auir_uart_assertions.sv
// Checker of bus handshakes and serial line timing for the serial port.
`timescale 1ns/100ps
module auir_uart_chk (
  // Clock, reset and bus handshakes.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial output.
  input wire logic serialOutPin
);
  // Run of high output samples; a short run is an infrared pulse, not a bit.
  logic [4:0] hiRun;
  always_ff @(posedge sys_clk) begin
    if (rst || !serialOutPin) begin
      hiRun <= 5'h00;
    end else if (hiRun != 5'h1F) begin
      hiRun <= hiRun + 5'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer changed early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  a_start_width: assert property ($fell(serialOutPin) && hiRun > 5'h07 |->
    !serialOutPin [*8]) else $error("low bit shorter than half a bit");
endmodule : auir_uart_chk

bind auir_uart auir_uart_chk u_chk (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serialOutPin);

// ===== sim/auir_uart_tb.sv
// Self-checking bench for the serial port: bus tasks, line scenarios, verdict.
`timescale 1ns/100ps
module auir_uart_tb;
  localparam int BIT = 16; // Clocks per bit with a divisor of 1.0.
  logic sys_clk, awReady, wReady, bValid, arReady, rValid, rxPin, txPin, txHit, rxHit;
  logic rst = 1'b1, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0;
  logic rReady = 1'b0;
  logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
  logic [31:0] wData = 32'h0, rData, v;
  logic [1:0] bResp, rResp;
  int mismatches = 0, testsRun = 0, cyc = 0;
  auir_uart u_dut (.sys_clk, .rst, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .serialInPin(rxPin), .serialOutPin(txPin), .txLevelHit(txHit), .rxLevelHit(rxHit));
  auir_line_peer #(.BIT(BIT)) u_peer (.sys_clk, .serialOutPin(txPin), .serialInPin(rxPin));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // A hang ends the run here instead of stalling forever.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  // Bus write: each channel is dropped at the edge that takes it.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    d = rData;
    rReady <= 1'b0;
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic s_reset();
    rd(auir_pkg::OFF_CTL, v);
    chk("ctl", 32'h00000300, v);
    rd(auir_pkg::OFF_IFLS, v);
    chk("ifls", 32'h00000012, v);
    chk("levels", 32'h00000002, {30'h0, txHit, rxHit});
    rd(auir_pkg::OFF_FLAG, v);
    chk("flag", 32'h00000090, v);
    rd(12'h100, v);
    chk("unmapped", 32'h00000000, v);
  endtask : s_reset
  // Eight bits, even parity, FIFOs on; two characters sent back to back.
  task automatic s_tx();
    wr(auir_pkg::OFF_CTL, 32'h0);
    wr(auir_pkg::OFF_IBRD, 32'h1);
    wr(auir_pkg::OFF_FBRD, 32'h0);
    wr(auir_pkg::OFF_LCTL, 32'h76);
    wr(auir_pkg::OFF_CTL, 32'h301);
    wr(auir_pkg::OFF_DATA, 32'hA5);
    wr(auir_pkg::OFF_DATA, 32'h07);
    rd(auir_pkg::OFF_FLAG, v);
    chk("busy", 32'h8, v & 32'h8);
    while (u_peer.frames.size() < 2) @(posedge sys_clk);
    chk("frame0", 32'h2A5, {22'h0, u_peer.frames[0]});
    chk("frame1", 32'h307, {22'h0, u_peer.frames[1]});
    repeat (BIT) @(posedge sys_clk);
    rd(auir_pkg::OFF_FLAG, v);
    chk("idle", 32'h80, v & 32'h88);
  endtask : s_tx
  task automatic s_rx();
    u_peer.glitch();
    u_peer.send(10'h331);
    rd(auir_pkg::OFF_DATA, v);
    chk("rxgood", 32'h31, v);
    rd(auir_pkg::OFF_FLAG, v);
    chk("rxempty", 32'h10, v & 32'h10);
    u_peer.send(10'h081);
    rd(auir_pkg::OFF_DATA, v);
    chk("rxframe", 32'h181, v);
    u_peer.send(10'h000);
    rd(auir_pkg::OFF_DATA, v);
    chk("rxbreak", 32'h500, v);
  endtask : s_rx
  task automatic s_ir();
    int n = 0;
    wr(auir_pkg::OFF_CTL, 32'h0);
    wr(auir_pkg::OFF_CTL, 32'h303);
    wr(auir_pkg::OFF_DATA, 32'h0);
    while (txPin !== 1'b1) @(posedge sys_clk);
    while (txPin === 1'b1) begin
      n++;
      @(posedge sys_clk);
    end
    chk("irpulse", 32'h3, 32'(n));
    // Transmit only here, so no receive follows inside the turnaround gap.
  endtask : s_ir
  task automatic close_out();
    $display("tests %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    s_reset();
    s_tx();
    s_rx();
    s_ir();
    close_out();
  end
endmodule : auir_uart_tb
